// File: core/cca_core.sv
// Condition code accumulator, global registers and constant-generation write paths.
//
// Overview of operation
// - Result written to register 2 loads the whole 32-bit accumulator.
// - Result written to register 3 shifts accumulator left, result MSB enters bit zero.
// - Reading register 2 as a source returns the accumulator contents.
// - Accumulator source allowed for all classes except floating-point unit ones.
// - Plain accumulator destination valid only for add, subtract and constant ops.
// - Reading the shift-in port is unsupported; any value may be returned.
// - Shift-in destination accepted except for the four load kinds.
// - Accumulator used as both source and destination gives undefined result.
// - No write-after-write interlock on accumulator destinations; order is arrival order.
// - Multiply, divide, root latency may vary with denormals unless flushing enabled.
// - Most instructions accept an eight-bit immediate as operand directly.
// - Low zero-extend constant writes low half, clears upper half.
// - High keep-low constant writes upper half, keeps lower half.
// - Low ones-extend constant writes low half, sets upper half to ones.
// - High zero-low constant writes upper half, clears lower half.
// - Relative jumps use 16-bit displacement; indirect jumps use a register.
// - Assert-equal of stack pointer with itself never traps, changes nothing.
// - Stack pointer is never subject to register access protection.
// - Denormal flush select bit enables treating denormal operands as zero.
`timescale 1ns/100ps
`default_nettype none

module cca_core
  import cca_pkg::*;
(
  input wire logic i_ref_clk, // Processor clock, 50 MHz.
  input wire logic i_nrst, // Asynchronous reset, active low.
  input wire cca_rd_s i_rd, // Operand read request.
  input wire cca_wb_s i_wb, // Result write-back.
  input wire logic i_user_mode, // High while a user-mode program runs.
  input wire logic [7:0] i_bank_protect, // One protect bit per 16-register bank.
  input wire logic i_denormal_flush_select, // Flush select bit of the float environment.
  output logic o_rd_valid, // Operands below are valid, one-cycle pulse.
  output logic [31:0] o_opnd_a, // First source operand.
  output logic [31:0] o_opnd_b, // Second source operand or immediate.
  output logic [31:0] o_condition_code_accumulator, // Current accumulator value.
  output logic o_protect_trap, // Protection violation pulse.
  output logic o_assert_trap, // Assert-equal failure pulse.
  output logic [7:0] o_assert_trap_num, // Trap number of the failed assertion.
  output logic o_jump_valid, // Jump target below is valid, one-cycle pulse.
  output logic [31:0] o_jump_target, // Computed branch target address.
  output logic o_misuse, // Unsupported accumulator use seen, one-cycle pulse.
  output logic o_flush_denormals, // Denormal operands are treated as zero.
  output logic o_latency_may_vary // Current read op may take extra denormal cycles.
);

  //////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Register number addresses the accumulator's plain port.
  function automatic logic is_accum(input logic [7:0] num);
    is_accum = (num == CCA_NUM_ACCUM);
  endfunction

  // Register number addresses the shift-in port.
  function automatic logic is_shift_in(input logic [7:0] num);
    is_shift_in = (num == CCA_NUM_SHIFT_IN);
  endfunction

  // Either accumulator number.
  function automatic logic is_any_accum(input logic [7:0] num);
    is_any_accum = is_accum(num) || is_shift_in(num);
  endfunction

  // Class executed in the floating-point unit.
  function automatic logic is_fpu(input cca_op_e op);
    is_fpu = (op == CCA_OP_FPU) || (op == CCA_OP_SINGLE_FLOAT_MULTIPLY_S) || (op == CCA_OP_SINGLE_FLOAT_MULTIPLY_D) ||
             (op == CCA_OP_FDIV_D) || (op == CCA_OP_FSQRT);
  endfunction

  // Any of the four load kinds.
  function automatic logic is_load(input cca_op_e op);
    is_load = (op == CCA_OP_LOAD) || (op == CCA_OP_LOAD_LOCKED) ||
              (op == CCA_OP_LOAD_MULTI) || (op == CCA_OP_LOAD_SET);
  endfunction

  // Classes that may name the plain accumulator as destination.
  function automatic logic accum_dest_ok(input cca_op_e op);
    accum_dest_ok = (op == CCA_OP_ADD) || (op == CCA_OP_SUB) || (op == CCA_OP_CONST_LZ) ||
                    (op == CCA_OP_CONST_HK) || (op == CCA_OP_CONST_LO) ||
                    (op == CCA_OP_CONST_HZ);
  endfunction

  // Register protected from this access; the stack pointer never is.
  function automatic logic is_protected(input logic [7:0] num, input logic user,
                                        input logic [7:0] banks);
    is_protected = user && !num[CCA_LOCAL_BIT] && (num != CCA_NUM_STACK_PTR) &&
                   banks[num[CCA_BANK_LSB +: CCA_BANK_W]];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Storage.

  logic [31:0] condition_code_accumulator;
  logic [31:0] global_regs [CCA_GLOBALS];
  logic [31:0] wb_old;
  logic [31:0] wb_value;
  logic wb_to_array;
  logic wb_to_accum;
  logic wb_to_shift;
  logic [31:0] next_accum;
  logic [31:0] src_a_val;
  logic [31:0] src_b_val;

  // Value currently held by the write-back destination, needed by the keep-low constant.
  always_comb begin
    if (is_accum(i_wb.dest)) begin
      wb_old = condition_code_accumulator;
    end else if (!i_wb.dest[CCA_LOCAL_BIT]) begin
      wb_old = global_regs[i_wb.dest[CCA_IDX_W-1:0]];
    end else begin
      wb_old = CCA_WORD_ZERO;
    end
  end

  // Result value as written; constant classes build it from the 16-bit field.
  always_comb begin
    unique case (i_wb.op)
      CCA_OP_CONST_LZ: wb_value = {CCA_HALF_ZERO, i_wb.imm16};
      CCA_OP_CONST_HK: wb_value = {i_wb.imm16, wb_old[CCA_HALF_W-1:0]};
      CCA_OP_CONST_LO: wb_value = {CCA_HALF_ONES, i_wb.imm16};
      CCA_OP_CONST_HZ: wb_value = {i_wb.imm16, CCA_HALF_ZERO};
      default: wb_value = i_wb.data;
    endcase
  end

  // Steering of the write-back to the accumulator ports or the array.
  // Loads into the shift-in port are refused, since their data arrives late.
  always_comb begin
    wb_to_accum = i_wb.valid && is_accum(i_wb.dest);
    wb_to_shift = i_wb.valid && is_shift_in(i_wb.dest) && !is_load(i_wb.op);
    wb_to_array = i_wb.valid && !i_wb.dest[CCA_LOCAL_BIT] && !is_any_accum(i_wb.dest);
  end

  // Next accumulator value for either write port.
  always_comb begin
    next_accum = condition_code_accumulator;
    if (wb_to_accum) begin
      next_accum = wb_value;
    end else if (wb_to_shift) begin
      next_accum = {condition_code_accumulator[CCA_DATA_W-2:0], wb_value[CCA_MSB]};
    end
  end

  // Accumulator register. No interlock orders writes: they land in arrival order,
  // so software must keep completion order fixed itself.
  // arrival order.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      condition_code_accumulator <= CCA_WORD_ZERO;
    end else begin
      condition_code_accumulator <= next_accum;
    end
  end

  // General register array; no reset so it maps onto plain storage.
  always_ff @(posedge i_ref_clk) begin
    if (wb_to_array) begin
      global_regs[i_wb.dest[CCA_IDX_W-1:0]] <= wb_value;
    end
  end

  assign o_condition_code_accumulator = condition_code_accumulator;

  //////////////////////////////////////////////////////////////////////////////
  // Operand read.

  // Source A lookup. The shift-in port has no read path and returns zero.
  always_comb begin
    if (is_accum(i_rd.src_a)) begin
      src_a_val = condition_code_accumulator;
    end else if (is_shift_in(i_rd.src_a) || i_rd.src_a[CCA_LOCAL_BIT]) begin
      src_a_val = CCA_WORD_ZERO;
    end else begin
      src_a_val = global_regs[i_rd.src_a[CCA_IDX_W-1:0]];
    end
  end

  // Source B lookup, or the zero-extended eight-bit immediate.
  always_comb begin
    if (i_rd.use_imm8) begin
      src_b_val = {24'h00_0000, i_rd.imm8};
    end else if (is_accum(i_rd.src_b)) begin
      src_b_val = condition_code_accumulator;
    end else if (is_shift_in(i_rd.src_b) || i_rd.src_b[CCA_LOCAL_BIT]) begin
      src_b_val = CCA_WORD_ZERO;
    end else begin
      src_b_val = global_regs[i_rd.src_b[CCA_IDX_W-1:0]];
    end
  end

  // Operand registers, loaded on every valid read request.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rd_valid <= 1'b0;
      o_opnd_a <= CCA_WORD_ZERO;
      o_opnd_b <= CCA_WORD_ZERO;
    end else begin
      o_rd_valid <= i_rd.valid;
      if (i_rd.valid) begin
        o_opnd_a <= src_a_val;
        o_opnd_b <= src_b_val;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Misuse detection. Misuse is flagged; only loads into the shift-in port are blocked, otherwise the result is simply undefined.

  logic misuse_src;
  logic misuse_dst;
  logic misuse_both;
  logic b_is_reg;

  always_comb begin
    b_is_reg = !i_rd.use_imm8;
    misuse_src = i_rd.valid && is_fpu(i_rd.op) &&
                 (is_accum(i_rd.src_a) || (b_is_reg && is_accum(i_rd.src_b)));
    misuse_both = i_rd.valid && is_any_accum(i_rd.dest) &&
                  (is_any_accum(i_rd.src_a) || (b_is_reg && is_any_accum(i_rd.src_b)));
    misuse_dst = i_wb.valid && ((is_accum(i_wb.dest) && !accum_dest_ok(i_wb.op)) ||
                                (is_shift_in(i_wb.dest) && is_load(i_wb.op)));
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_misuse <= 1'b0;
    end else begin
      o_misuse <= misuse_src || misuse_both || misuse_dst;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Protection and assert-equal.

  logic prot_hit;
  logic same_reg;
  logic assert_fail;

  // An access to a protected bank from user mode traps; the assert-equal trap
  // is skipped whenever both operands name one register, so the stack pointer compared with itself never traps.
  always_comb begin
    prot_hit = i_rd.valid && (is_protected(i_rd.src_a, i_user_mode, i_bank_protect) ||
               (b_is_reg && is_protected(i_rd.src_b, i_user_mode, i_bank_protect)));
    // One register compared with itself is equal by definition; this also keeps an
    // unwritten register (no reset on the array) from raising a false trap.
    same_reg = !i_rd.use_imm8 && (i_rd.src_a == i_rd.src_b);
    assert_fail = i_rd.valid && (i_rd.op == CCA_OP_ASSERT_EQ) && !prot_hit && !same_reg &&
                  (src_a_val != src_b_val);
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_protect_trap <= 1'b0;
      o_assert_trap <= 1'b0;
      o_assert_trap_num <= CCA_NOP_TRAP_NUM;
    end else begin
      o_protect_trap <= prot_hit;
      o_assert_trap <= assert_fail;
      if (assert_fail) begin
        o_assert_trap_num <= i_rd.imm8;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Branch targets.

  logic [31:0] rel_target;

  // Displacement is in words, sign-extended; far targets go through a register.
  always_comb begin
    rel_target = i_rd.pc + {{(CCA_DATA_W - CCA_HALF_W - CCA_WORD_SHIFT){i_rd.imm16[CCA_HALF_W-1]}},
                            i_rd.imm16, 2'b00};
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_jump_valid <= 1'b0;
      o_jump_target <= CCA_WORD_ZERO;
    end else begin
      o_jump_valid <= i_rd.valid &&
                      ((i_rd.op == CCA_OP_JUMP_REL) || (i_rd.op == CCA_OP_JUMP_IND));
      if (i_rd.valid && (i_rd.op == CCA_OP_JUMP_REL)) begin
        o_jump_target <= rel_target;
      end else if (i_rd.valid && (i_rd.op == CCA_OP_JUMP_IND)) begin
        o_jump_target <= src_a_val;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Denormal handling status.

  // Flush mode and the latency hint are plain levels for the float unit.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_flush_denormals <= 1'b0;
      o_latency_may_vary <= 1'b0;
    end else begin
      o_flush_denormals <= i_denormal_flush_select;
      o_latency_may_vary <= i_rd.valid && !i_denormal_flush_select &&
                            ((i_rd.op == CCA_OP_SINGLE_FLOAT_MULTIPLY_S) || (i_rd.op == CCA_OP_SINGLE_FLOAT_MULTIPLY_D) ||
                             (i_rd.op == CCA_OP_FDIV_D) || (i_rd.op == CCA_OP_FSQRT));
    end
  end

endmodule

`default_nettype wire

// File: core/cca_pkg.sv
// Package for the condition code accumulator and constant generation block.
package cca_pkg;

  // Register numbering of the global register space.
  localparam int unsigned CCA_REG_W = 8;
  localparam int unsigned CCA_DATA_W = 32;
  localparam int unsigned CCA_HALF_W = 16;
  localparam int unsigned CCA_IMM8_W = 8;
  localparam int unsigned CCA_GLOBALS = 128;
  localparam int unsigned CCA_IDX_W = 7;
  localparam int unsigned CCA_BANKS = 8;
  localparam int unsigned CCA_BANK_W = 3;
  localparam int unsigned CCA_BANK_LSB = 4;
  localparam int unsigned CCA_LOCAL_BIT = 7;
  localparam int unsigned CCA_MSB = 31;
  localparam int unsigned CCA_WORD_SHIFT = 2;

  // Fixed register numbers.
  localparam logic [7:0] CCA_NUM_STACK_PTR = 8'h01;
  localparam logic [7:0] CCA_NUM_ACCUM = 8'h02;
  localparam logic [7:0] CCA_NUM_SHIFT_IN = 8'h03;

  // Trap number used by the no-operation form of assert-equal.
  localparam logic [7:0] CCA_NOP_TRAP_NUM = 8'h40;

  // Fill values for the constant-generation halves.
  localparam logic [15:0] CCA_HALF_ZERO = 16'h0000;
  localparam logic [15:0] CCA_HALF_ONES = 16'hFFFF;
  localparam logic [31:0] CCA_WORD_ZERO = 32'h0000_0000;

  // Instruction class presented by the execution pipeline.
  typedef enum logic [4:0] {
    CCA_OP_ALU = 5'b00000,
    CCA_OP_ADD = 5'b00001,
    CCA_OP_SUB = 5'b00010,
    CCA_OP_CONST_LZ = 5'b00011,
    CCA_OP_CONST_HK = 5'b00100,
    CCA_OP_CONST_LO = 5'b00101,
    CCA_OP_CONST_HZ = 5'b00110,
    CCA_OP_LOAD = 5'b00111,
    CCA_OP_LOAD_LOCKED = 5'b01000,
    CCA_OP_LOAD_MULTI = 5'b01001,
    CCA_OP_LOAD_SET = 5'b01010,
    CCA_OP_FPU = 5'b01011,
    CCA_OP_SINGLE_FLOAT_MULTIPLY_S = 5'b01100,
    CCA_OP_SINGLE_FLOAT_MULTIPLY_D = 5'b01101,
    CCA_OP_FDIV_D = 5'b01110,
    CCA_OP_FSQRT = 5'b01111,
    CCA_OP_ASSERT_EQ = 5'b10000,
    CCA_OP_JUMP_REL = 5'b10001,
    CCA_OP_JUMP_IND = 5'b10010
  } cca_op_e;

  // Operand read request from the decode stage.
  typedef struct packed {
    logic valid;
    cca_op_e op;
    logic [7:0] src_a;
    logic [7:0] src_b;
    logic [7:0] dest;
    logic use_imm8;
    logic [7:0] imm8;
    logic [15:0] imm16;
    logic [31:0] pc;
  } cca_rd_s;

  // Result write-back from the end of the pipeline.
  typedef struct packed {
    logic valid;
    cca_op_e op;
    logic [7:0] dest;
    logic [15:0] imm16;
    logic [31:0] data;
  } cca_wb_s;

endpackage

// File: dv/cca_core_asserts.sv
// Port-level checker for the accumulator and constant-generation block.
`timescale 1ns/100ps
`default_nettype none
module cca_core_asserts
  import cca_pkg::*;
(
  input wire logic i_ref_clk, // Clock.
  input wire logic i_nrst, // Reset, active low.
  input wire cca_rd_s i_rd, // Read request.
  input wire cca_wb_s i_wb, // Write-back.
  input wire logic o_rd_valid, // Read answer strobe.
  input wire logic [31:0] o_opnd_a, // First operand.
  input wire logic [31:0] o_condition_code_accumulator, // Accumulator.
  input wire logic o_protect_trap, // Protection trap.
  input wire logic o_assert_trap, // Assert trap.
  input wire logic o_jump_valid, // Jump strobe.
  input wire logic [31:0] o_jump_target // Jump target.
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);
  logic [31:0] acc;
  logic [31:0] rel;
  logic [30:0] acc_sh;
  logic [15:0] acc_lo;
  logic dmsb;
  logic w2;
  logic w3;
  logic nop;
  // Helper terms; the relative target is built here so $past sees one signal.
  assign acc = o_condition_code_accumulator;
  assign acc_sh = acc[30:0];
  assign acc_lo = acc[15:0];
  assign dmsb = i_wb.data[31];
  assign rel = i_rd.pc + {{14{i_rd.imm16[15]}}, i_rd.imm16, 2'b00};
  assign w2 = i_wb.valid && i_wb.dest == CCA_NUM_ACCUM;
  assign w3 = i_wb.valid && i_wb.dest == CCA_NUM_SHIFT_IN
    && i_wb.op inside {CCA_OP_ALU, CCA_OP_ADD, CCA_OP_SUB, CCA_OP_FPU};
  assign nop = i_rd.valid && i_rd.op == CCA_OP_ASSERT_EQ && !i_rd.use_imm8 && !i_wb.valid
    && i_rd.src_a == CCA_NUM_STACK_PTR && i_rd.src_b == CCA_NUM_STACK_PTR;
  property p_load;
    w2 && i_wb.op inside {CCA_OP_ADD, CCA_OP_SUB} |=> acc == $past(i_wb.data);
  endproperty
  a_load: assert property (p_load) else $error("accumulator load wrong");
  property p_shift;
    w3 |=> acc == {$past(acc_sh), $past(dmsb)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift-in wrong");
  property p_read;
    i_rd.valid && i_rd.src_a == CCA_NUM_ACCUM |=> o_rd_valid && o_opnd_a == $past(acc);
  endproperty
  a_read: assert property (p_read) else $error("accumulator read wrong");
  property p_later;
    w2 && i_wb.op == CCA_OP_ADD ##1 !i_wb.valid ##1 i_rd.valid && i_rd.src_a == CCA_NUM_ACCUM
      |=> o_opnd_a == $past(i_wb.data, 3);
  endproperty
  a_later: assert property (p_later) else $error("later read stale");
  property p_lz;
    w2 && i_wb.op == CCA_OP_CONST_LZ |=> acc == {CCA_HALF_ZERO, $past(i_wb.imm16)};
  endproperty
  a_lz: assert property (p_lz) else $error("low zero constant wrong");
  property p_hk;
    w2 && i_wb.op == CCA_OP_CONST_HK |=> acc == {$past(i_wb.imm16), $past(acc_lo)};
  endproperty
  a_hk: assert property (p_hk) else $error("high keep constant wrong");
  property p_lo;
    w2 && i_wb.op == CCA_OP_CONST_LO |=> acc == {CCA_HALF_ONES, $past(i_wb.imm16)};
  endproperty
  a_lo: assert property (p_lo) else $error("negative constant wrong");
  property p_hz;
    w2 && i_wb.op == CCA_OP_CONST_HZ |=> acc == {$past(i_wb.imm16), CCA_HALF_ZERO};
  endproperty
  a_hz: assert property (p_hz) else $error("high zero constant wrong");
  property p_jump;
    i_rd.valid && i_rd.op == CCA_OP_JUMP_REL |=> o_jump_valid && o_jump_target == $past(rel);
  endproperty
  a_jump: assert property (p_jump) else $error("relative target wrong");
  property p_nop;
    nop |=> !o_assert_trap && !o_protect_trap && $stable(acc);
  endproperty
  a_nop: assert property (p_nop) else $error("stack pointer no-op acted");
  // Main scenarios reached.
  c_shift: cover property (w3);
  c_jump: cover property (i_rd.valid && i_rd.op == CCA_OP_JUMP_REL);
  c_nop: cover property (nop);
endmodule
bind cca_core cca_core_asserts cca_core_asserts_i (
  .i_ref_clk, .i_nrst, .i_rd, .i_wb, .o_rd_valid, .o_opnd_a,
  .o_condition_code_accumulator, .o_protect_trap, .o_assert_trap,
  .o_jump_valid, .o_jump_target
);
`default_nettype wire

// File: dv/cca_pipe_model.sv
// Execution pipeline model that hands requests to the block.
`timescale 1ns/100ps
`default_nettype none
module cca_pipe_model
  import cca_pkg::*;
(
  input wire cca_rd_s i_rd_req, // Read request from the bench.
  input wire cca_wb_s i_wb_req, // Write-back from the bench.
  input wire logic i_stall, // Drops the valid of both streams while high.
  output var cca_rd_s o_rd, // Read request to the block.
  output var cca_wb_s o_wb // Write-back to the block.
);
  // Results go out in arrival order with no write-after-write wait; an idle
  // slot never repeats old data, so a stale payload cannot pass for a result.
  always_comb begin
    o_rd = i_rd_req;
    o_wb = i_wb_req;
    o_rd.valid = i_rd_req.valid && !i_stall;
    o_wb.valid = i_wb_req.valid && !i_stall;
    if (!o_wb.valid) o_wb.data = ~i_wb_req.data;
  end
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the accumulator and constant-generation block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import cca_pkg::*;
  logic i_ref_clk, i_nrst, stall, umode, flush, u;
  logic rv, pt, at, jv, mu, fd, lv;
  logic [7:0] prot, an, d, i8;
  logic [15:0] k;
  logic [31:0] oa, ob, acc, jt, ea, eo, v;
  cca_rd_s rq, rd;
  cca_wb_s wq, wb;
  cca_op_e op;
  int bad_count, num_checks, seed, n;
  cca_op_e ops2[6] = '{CCA_OP_ADD, CCA_OP_SUB, CCA_OP_CONST_LZ,
    CCA_OP_CONST_HK, CCA_OP_CONST_LO, CCA_OP_CONST_HZ};
  cca_op_e ops3[4] = '{CCA_OP_ALU, CCA_OP_ADD, CCA_OP_SUB, CCA_OP_FPU};
  cca_op_e ldo[4] = '{CCA_OP_LOAD, CCA_OP_LOAD_LOCKED, CCA_OP_LOAD_MULTI, CCA_OP_LOAD_SET};
  cca_op_e fpo[4] = '{CCA_OP_SINGLE_FLOAT_MULTIPLY_S, CCA_OP_SINGLE_FLOAT_MULTIPLY_D, CCA_OP_FDIV_D, CCA_OP_FSQRT};
  logic [15:0] kj[4] = '{16'h0000, 16'h7FFF, 16'h8000, 16'hFFFF};
  cca_pipe_model cca_pipe_model_i (.i_rd_req(rq), .i_wb_req(wq), .i_stall(stall),
    .o_rd(rd), .o_wb(wb));
  cca_core cca_core_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_rd(rd), .i_wb(wb),
    .i_user_mode(umode), .i_bank_protect(prot), .i_denormal_flush_select(flush),
    .o_rd_valid(rv), .o_opnd_a(oa), .o_opnd_b(ob), .o_condition_code_accumulator(acc),
    .o_protect_trap(pt), .o_assert_trap(at), .o_assert_trap_num(an), .o_jump_valid(jv),
    .o_jump_target(jt), .o_misuse(mu), .o_flush_denormals(fd), .o_latency_may_vary(lv));
  // Free-running 50 MHz clock.
  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  // Comparison of a word, and of a flag widened to a word.
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  // One request slot: driven at an edge, taken at the next, checked just after it.
  task automatic go(input cca_rd_s r, input cca_wb_s w, input logic s = 1'b0);
    @(posedge i_ref_clk);
    rq <= r;
    wq <= w;
    stall <= s;
    @(posedge i_ref_clk);
    rq <= '0;
    wq <= '0;
    stall <= 1'b0;
    #1;
  endtask
  function automatic cca_rd_s mk_rd(input cca_op_e o, input logic [7:0] a, b, e,
      input logic uu, input logic [7:0] i, input logic [15:0] kk, input logic [31:0] p);
    return '{1'b1, o, a, b, e, uu, i, kk, p};
  endfunction
  function automatic cca_wb_s mk_wb(input cca_op_e o, input logic [7:0] e,
      input logic [15:0] kk, input logic [31:0] x);
    return '{1'b1, o, e, kk, x};
  endfunction
  // Expected accumulator after a write-back; shift-in keeps only the result's top bit.
  function automatic logic [31:0] nxt(input cca_op_e o, input logic [7:0] e,
      input logic [15:0] kk, input logic [31:0] x, input logic [31:0] old);
    logic [31:0] r;
    case (o)
      CCA_OP_CONST_LZ: r = {CCA_HALF_ZERO, kk};
      CCA_OP_CONST_HK: r = {kk, old[15:0]};
      CCA_OP_CONST_LO: r = {CCA_HALF_ONES, kk};
      CCA_OP_CONST_HZ: r = {kk, CCA_HALF_ZERO};
      default: r = x;
    endcase
    return (e == CCA_NUM_SHIFT_IN) ? {old[30:0], r[31]} : r;
  endfunction
  // Closing verdict, reached from the tests and from the watchdog.
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Watchdog sized well above the few hundred cycles the tests need.
  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end
  // Main sequence.
  initial begin
    seed = 61461;
    bad_count = 0;
    num_checks = 0;
    {i_nrst, stall, umode, flush, prot, rq, wq} = '0;
    repeat (8) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    #1;
    chk32(acc, CCA_WORD_ZERO);
    chk32({24'h0, an}, {24'h0, CCA_NOP_TRAP_NUM});
    ea = CCA_WORD_ZERO;
    // Random writes through both numbers, each with a same-slot read of the plain number.
    for (n = 0; n < 200; n++) begin
      d = ($random(seed) & 1) ? CCA_NUM_SHIFT_IN : CCA_NUM_ACCUM;
      op = (d == CCA_NUM_ACCUM) ? ops2[$unsigned($random(seed)) % 6]
        : ops3[$unsigned($random(seed)) % 4];
      k = $random(seed);
      v = (n == 0) ? 32'h8000_0000 : $random(seed);
      u = $random(seed);
      i8 = $random(seed);
      eo = ea;
      ea = nxt(op, d, k, v, ea);
      go(mk_rd(CCA_OP_ALU, CCA_NUM_ACCUM, 8'h61, 8'h60, u, i8, 16'h0000, 32'h0), mk_wb(op, d, k, v));
      chk1(rv, 1'b1);
      chk32(oa, eo);
      chk32(acc, ea);
      chk1(mu, 1'b0);
      if (u) chk32(ob, {24'h0, i8});
    end
    // A stalled write is dropped, not applied; only the copy sent again without stall lands.
    v = $random(seed);
    go('0, mk_wb(CCA_OP_ADD, CCA_NUM_ACCUM, 16'h0000, v), 1'b1);
    chk32(acc, ea);
    ea = v;
    go('0, mk_wb(CCA_OP_ADD, CCA_NUM_ACCUM, 16'h0000, v));
    chk32(acc, ea);
    $display("end random writes");
    // Relative displacement edges, then an indirect jump through the accumulator.
    foreach (kj[i]) begin
      v = $random(seed);
      go(mk_rd(CCA_OP_JUMP_REL, 8'h60, 8'h61, 8'h62, 1'b0, 8'h00, kj[i], v), '0);
      chk1(jv, 1'b1);
      chk32(jt, v + {{14{kj[i][15]}}, kj[i], 2'b00});
    end
    go(mk_rd(CCA_OP_JUMP_IND, CCA_NUM_ACCUM, 8'h61, 8'h62, 1'b0, 8'h00, 16'h0000, 32'h0), '0);
    chk32(jt, ea);
    // Assert-equal of the accumulator against an immediate traps when they differ.
    go(mk_rd(CCA_OP_ASSERT_EQ, CCA_NUM_ACCUM, 8'h61, 8'h62, 1'b1, 8'h5A, 16'h0000, 32'h0), '0);
    chk1(at, ea != 32'h0000_005A);
    chk32({24'h0, an}, (ea != 32'h0000_005A) ? 32'h0000_005A : {24'h0, CCA_NOP_TRAP_NUM});
    $display("end jumps");
    // Stack pointer no-op in user mode with every bank protected, then a protected read.
    @(posedge i_ref_clk);
    umode <= 1'b1;
    prot <= 8'hFF;
    go(mk_rd(CCA_OP_ASSERT_EQ, CCA_NUM_STACK_PTR, CCA_NUM_STACK_PTR, 8'h00, 1'b0,
      CCA_NOP_TRAP_NUM, 16'h0000, 32'h0), '0);
    chk1(at, 1'b0);
    chk1(pt, 1'b0);
    chk32(acc, ea);
    go(mk_rd(CCA_OP_ALU, 8'h60, CCA_NUM_STACK_PTR, 8'h62, 1'b0, 8'h00, 16'h0000, 32'h0), '0);
    chk1(pt, 1'b1);
    @(posedge i_ref_clk);
    umode <= 1'b0;
    // Accumulator as a floating-point source, and every load kind into the shift-in port.
    go(mk_rd(CCA_OP_FPU, CCA_NUM_ACCUM, 8'h61, 8'h60, 1'b0, 8'h00, 16'h0000, 32'h0), '0);
    chk1(mu, 1'b1);
    go(mk_rd(CCA_OP_ADD, CCA_NUM_ACCUM, 8'h61, CCA_NUM_SHIFT_IN, 1'b0, 8'h00, 16'h0000, 32'h0), '0);
    chk1(mu, 1'b1);
    v = $random(seed);
    go('0, mk_wb(CCA_OP_ALU, CCA_NUM_ACCUM, 16'h0000, v));
    ea = v;
    chk32(acc, ea);
    chk1(mu, 1'b1);
    foreach (ldo[i]) begin
      go('0, mk_wb(ldo[i], CCA_NUM_SHIFT_IN, 16'h0000, 32'hFFFF_FFFF));
      chk32(acc, ea);
      chk1(mu, 1'b1);
    end
    $display("end protection and misuse");
    // Variable-latency hint on the slow float ops, with and without flushing.
    for (n = 0; n < 8; n++) begin
      @(posedge i_ref_clk);
      flush <= n[2];
      @(posedge i_ref_clk);
      go(mk_rd(fpo[n % 4], 8'h60, 8'h61, 8'h62, 1'b0, 8'h00, 16'h0000, 32'h0), '0);
      chk1(fd, n[2]);
      chk1(lv, !n[2]);
    end
    $display("end flush");
    tally_and_finish();
  end
endmodule
`default_nettype wire
